// File: rtl/irc_top.sv
// ir transmitter interrupt counter with ahb-lite register slave
//------------------------------------------------------------
//------------------------------------------------------------
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "irc_consts.svh"
module irc_top
	import irc_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic CE,
	input wire logic CARRIER_TICK,
	input wire logic GLOBAL_IRQ_EN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic CIRCUIT_RUN,
	output logic IRQ_REQ
);
	//------------------------------------------------------------
	// bus address phase capture
	//------------------------------------------------------------
	irc_ahb_req_t req;
	logic dph_valid, next_dph_valid;
	logic dph_write, next_dph_write;
	logic [7:0] dph_addr, next_dph_addr;
	assign req = '{sel: HSEL, trans: HTRANS, write: HWRITE,
		size: HSIZE, addr: HADDR};
	// the slave never stalls, so every transfer is one data cycle
	always_comb begin
		next_dph_valid = req.sel && req.trans[1] && HREADY;
		next_dph_write = req.write;
		next_dph_addr = req.addr[7:0];
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			dph_valid <= 1'b0;
			dph_write <= 1'b0;
			dph_addr <= '0;
		end else if (CE) begin
			dph_valid <= next_dph_valid;
			dph_write <= next_dph_write;
			dph_addr <= next_dph_addr;
		end
	end
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	logic wr_factor, wr_mask, wr_tau, wr_count, rd_factor;
	always_comb begin
		wr_factor = 1'b0;
		wr_mask = 1'b0;
		wr_tau = 1'b0;
		wr_count = 1'b0;
		rd_factor = 1'b0;
		if (dph_valid && dph_addr == `IRC_OFF_FACTOR) begin
			wr_factor = dph_write;
			rd_factor = !dph_write;
		end else if (dph_valid && dph_addr == `IRC_OFF_MASK) begin
			wr_mask = dph_write;
		end else if (dph_valid && dph_addr == `IRC_OFF_TAU) begin
			wr_tau = dph_write;
		end else if (dph_valid && dph_addr == `IRC_OFF_COUNT) begin
			wr_count = dph_write;
		end
	end

	//------------------------------------------------------------
	// control registers
	//------------------------------------------------------------
	logic circuit_on, next_circuit_on;
	logic ir_irq_mask, next_ir_irq_mask;
	logic forced_output_ctrl, next_forced_output_ctrl;
	logic [3:0] tau_upper, next_tau_upper;
	logic [1:0] tau_sel, next_tau_sel;
	logic [3:0] irq_count_setting, next_irq_count_setting;

	// software must not hit these while running; hardware does not block
	always_comb begin
		next_circuit_on = circuit_on;
		next_ir_irq_mask = ir_irq_mask;
		next_forced_output_ctrl = forced_output_ctrl;
		next_tau_upper = tau_upper;
		next_tau_sel = tau_sel;
		next_irq_count_setting = irq_count_setting;
		if (wr_mask) begin
			next_circuit_on = HWDATA[`IRC_BIT_CIRCUIT_ON];
			next_ir_irq_mask = HWDATA[`IRC_BIT_MASK];
		end
		if (wr_factor) begin
			next_forced_output_ctrl = HWDATA[`IRC_BIT_FORCED];
		end
		if (wr_tau) begin
			next_tau_upper = HWDATA[3:0];
			next_tau_sel = HWDATA[1:0];
		end
		if (wr_count) begin
			next_irq_count_setting = HWDATA[3:0];
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			circuit_on <= `IRC_RST_CIRCUIT_ON;
			ir_irq_mask <= `IRC_RST_MASK;
			forced_output_ctrl <= 1'b0;
			tau_upper <= '0;
			tau_sel <= `IRC_RST_TAU_SEL;
			irq_count_setting <= '0;
		end else if (CE) begin
			circuit_on <= next_circuit_on;
			ir_irq_mask <= next_ir_irq_mask;
			forced_output_ctrl <= next_forced_output_ctrl;
			tau_upper <= next_tau_upper;
			tau_sel <= next_tau_sel;
			irq_count_setting <= next_irq_count_setting;
		end
	end

	//------------------------------------------------------------
	// run state: stops only on a tau boundary
	//------------------------------------------------------------
	logic run, next_run;
	logic tau_rise;
	always_comb begin
		next_run = run;
		if (circuit_on) begin
			next_run = 1'b1;
		end else if (tau_rise) begin
			next_run = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			run <= `IRC_RST_CIRCUIT_ON;
		end else if (CE) begin
			run <= next_run;
		end
	end
	assign CIRCUIT_RUN = run;
	irc_tau_gen u_tau (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.ce(CE),
		.run(run),
		.carrier_tick(CARRIER_TICK),
		.sel(tau_sel),
		.tau_rise(tau_rise)
	);

	//------------------------------------------------------------
	// interrupt counter
	//------------------------------------------------------------
	irc_state_t state, next_state;
	logic [3:0] remain, next_remain;
	logic event_pulse;

	// a zero count fires on the first tau rise, n counts n tau periods
	always_comb begin
		next_state = state;
		next_remain = remain;
		event_pulse = 1'b0;
		case (state)
			IRC_IDLE: begin
				if (wr_count) begin
					next_state = IRC_ARMED;
				end
			end
			IRC_ARMED: begin
				if (tau_rise) begin
					if (irq_count_setting == '0) begin
						event_pulse = 1'b1;
						next_state = IRC_IDLE;
					end else begin
						next_remain = irq_count_setting;
						next_state = IRC_COUNT;
					end
				end
			end
			IRC_COUNT: begin
				if (tau_rise) begin
					if (remain == `IRC_CNT_ONE) begin
						event_pulse = 1'b1;
						next_state = IRC_IDLE;
					end else begin
						next_remain = remain - `IRC_CNT_ONE;
					end
				end
			end
			default: next_state = IRC_IDLE;
		endcase
		// a rewrite restarts the wait for the next tau rise
		if (wr_count) begin
			next_state = IRC_ARMED;
		end
		if (!run) begin
			next_state = IRC_IDLE;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			state <= IRC_IDLE;
			remain <= '0;
		end else if (CE) begin
			state <= next_state;
			remain <= next_remain;
		end
	end

	//------------------------------------------------------------
	// factor flag and request
	//------------------------------------------------------------
	logic ir_irq_factor_flag, next_ir_irq_factor_flag;
	// set beats read clear so a coincident event is kept
	always_comb begin
		next_ir_irq_factor_flag = ir_irq_factor_flag;
		if (event_pulse) begin
			next_ir_irq_factor_flag = 1'b1;
		end else if (rd_factor) begin
			next_ir_irq_factor_flag = 1'b0;
		end
	end

	// flag resets to 0 here; software must still treat it as unknown
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			ir_irq_factor_flag <= 1'b0;
		end else if (CE) begin
			ir_irq_factor_flag <= next_ir_irq_factor_flag;
		end
	end

	assign IRQ_REQ = ir_irq_factor_flag && ir_irq_mask
		&& GLOBAL_IRQ_EN;
	//------------------------------------------------------------
	// read data
	//------------------------------------------------------------
	logic [31:0] next_hrdata;
	always_comb begin
		next_hrdata = '0;
		if (next_dph_valid && !req.write) begin
			if (req.addr[7:0] == `IRC_OFF_FACTOR) begin
				next_hrdata[`IRC_BIT_FORCED] = forced_output_ctrl;
				next_hrdata[`IRC_BIT_FLAG] = next_ir_irq_factor_flag;
			end else if (req.addr[7:0] == `IRC_OFF_MASK) begin
				next_hrdata[`IRC_BIT_CIRCUIT_ON] = next_circuit_on;
				next_hrdata[`IRC_BIT_MASK] = next_ir_irq_mask;
				next_hrdata[`IRC_BIT_GIE] = run;
			end else if (req.addr[7:0] == `IRC_OFF_TAU) begin
				next_hrdata[3:0] = next_tau_upper;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			HRDATA <= '0;
		end else if (CE) begin
			HRDATA <= next_hrdata;
		end
	end
endmodule
`default_nettype wire

// File: rtl/irc_consts.svh
// constants for the ir transmitter interrupt counter
`ifndef IRC_CONSTS_SVH
`define IRC_CONSTS_SVH

//------------------------------------------------------------
// register byte offsets
//------------------------------------------------------------
`define IRC_OFF_FACTOR 8'hf0
`define IRC_OFF_MASK 8'hf2
`define IRC_OFF_TAU 8'hf7
`define IRC_OFF_COUNT 8'hf8

//------------------------------------------------------------
// field positions
//------------------------------------------------------------
`define IRC_BIT_FORCED 3
`define IRC_BIT_FLAG 2
`define IRC_BIT_CIRCUIT_ON 3
`define IRC_BIT_MASK 2
`define IRC_BIT_GIE 0

//------------------------------------------------------------
// reset values and divider ratios
//------------------------------------------------------------
`define IRC_RST_CIRCUIT_ON 1'b1
`define IRC_RST_MASK 1'b0
`define IRC_RST_TAU_SEL 2'h0
`define IRC_DIV_12 6'd12
`define IRC_DIV_16 6'd16
`define IRC_DIV_20 6'd20
`define IRC_DIV_32 6'd32
`define IRC_CNT_ONE 4'h1
`define IRC_DIV_ONE 6'd1

`endif

// File: rtl/irc_pkg.sv
// types for the ir transmitter interrupt counter
package irc_pkg;
	typedef enum logic [1:0] {
		IRC_IDLE = 2'b00,
		IRC_ARMED = 2'b01,
		IRC_COUNT = 2'b10
	} irc_state_t;

	// ahb-lite request as seen by the slave
	typedef struct packed {
		logic sel;
		logic [1:0] trans;
		logic write;
		logic [2:0] size;
		logic [31:0] addr;
	} irc_ahb_req_t;
endpackage

// File: rtl/irc_tau_gen.sv
// tau reference generator: divides the carrier tick by 12/16/20/32
`timescale 1ns/1ns
`default_nettype none
`include "irc_consts.svh"
module irc_tau_gen
	import irc_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic run,
	input wire logic carrier_tick,
	input wire logic [1:0] sel,
	output logic tau_rise
);
	logic [5:0] cnt;
	logic [5:0] next_cnt;
	logic [5:0] ratio;
	logic next_tau_rise;

	// ratio lookup and count; a stopped circuit holds the count at zero
	always_comb begin
		case (sel)
			2'h0: ratio = `IRC_DIV_12;
			2'h1: ratio = `IRC_DIV_16;
			2'h2: ratio = `IRC_DIV_20;
			default: ratio = `IRC_DIV_32;
		endcase
		next_cnt = cnt;
		next_tau_rise = 1'b0;
		if (!run) begin
			next_cnt = '0;
		end else if (carrier_tick) begin
			if (cnt >= ratio - `IRC_DIV_ONE) begin
				next_cnt = '0;
				next_tau_rise = 1'b1;
			end else begin
				next_cnt = cnt + `IRC_DIV_ONE;
			end
		end
	end

	// registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= '0;
			tau_rise <= 1'b0;
		end else if (ce) begin
			cnt <= next_cnt;
			tau_rise <= next_tau_rise;
		end
	end
endmodule
`default_nettype wire

// File: bench/irc_properties.sv
// port checker for the ir transmitter interrupt counter
`timescale 1ns/1ns
`default_nettype none
`include "irc_consts.svh"
module irc_properties
	import irc_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic CE,
	input wire logic CARRIER_TICK,
	input wire logic GLOBAL_IRQ_EN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic CIRCUIT_RUN,
	input wire logic IRQ_REQ
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	// address phase taken this cycle; its data phase acts next cycle
	logic taken;
	assign taken = HSEL && HTRANS[1] && HREADY && CE;
	//----------------------------------------
	// bus phases
	//----------------------------------------
	// a write address phase that the slave takes
	sequence wr_take_s;
		HSEL && HTRANS[1] && HREADY && CE && HWRITE;
	endsequence
	// flag read: address phase, then its data phase
	sequence flag_rd_s;
		HSEL && HTRANS[1] && HREADY && CE && !HWRITE &&
			HADDR == {24'h0, `IRC_OFF_FACTOR} ##1 CE;
	endsequence
	//----------------------------------------
	// assertions
	//----------------------------------------
	chk_irq_global: assert property (IRQ_REQ |-> GLOBAL_IRQ_EN)
		else $error("request without global enable");
	chk_resp_okay: assert property (!HRESP && HREADYOUT)
		else $error("slave not ready or not okay");
	chk_write_zero: assert property (wr_take_s |=> HRDATA == 32'h0)
		else $error("read data not zero after write");
	chk_read_clear: assert property (flag_rd_s |=> !IRQ_REQ)
		else $error("flag not cleared by read");
	chk_run_reset: assert property ($rose(RESET_N) |-> CIRCUIT_RUN)
		else $error("circuit not on after reset");
	chk_ce_freeze: assert property (!CE |=>
		$stable(HRDATA) && $stable(CIRCUIT_RUN))
		else $error("state moved while disabled");
	// stop lands only on a tau rise, which trails its closing tick
	chk_stop_tau: assert property ($fell(CIRCUIT_RUN) |->
		$past(CARRIER_TICK, 2))
		else $error("circuit stopped off a tau boundary");
	// a pending request only goes away through a bus access or the enable
	chk_irq_holds: assert property (IRQ_REQ && !$past(taken) |=>
		IRQ_REQ || !GLOBAL_IRQ_EN)
		else $error("pending request dropped without a bus access");
endmodule
bind irc_top irc_properties u_chk (.CLK_SYS, .RESET_N, .CE, .CARRIER_TICK,
	.GLOBAL_IRQ_EN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY, .HRDATA,
	.HREADYOUT, .HRESP, .CIRCUIT_RUN, .IRQ_REQ);
`default_nettype wire

// File: bench/irc_top_tb.sv
// self-checking bench for the ir transmitter interrupt counter
`timescale 1ns/1ns
`default_nettype none
module irc_top_tb;
	import irc_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, tick = 1'b0, gie = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, hrdyo, hresp, run, irq, rd_dp = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [31:0] exp_q[$];
	int fails = 0, n_compared = 0, c, n, dv;
	irc_top dut (.CLK_SYS(clk), .RESET_N(rst_n), .CE(ce), .CARRIER_TICK(tick),
		.GLOBAL_IRQ_EN(gie), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdyo),
		.HRDATA(hrdata), .HREADYOUT(hrdyo), .HRESP(hresp),
		.CIRCUIT_RUN(run), .IRQ_REQ(irq));
	//----------------------------------------
	// clock, carrier and read monitor
	//----------------------------------------
	always #20 clk = ~clk;
	// carrier every other cycle, so tau is twice the divide ratio
	always @(posedge clk) tick <= ~tick;
	// data phase of a taken read: compare with oldest note
	always @(posedge clk) begin
		if (rd_dp && exp_q.size() > 0) begin
			chk("hrdata", exp_q.pop_front(), hrdata);
		end
		rd_dp <= hsel && htrans[1] && hrdyo && !hwrite && ce;
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one single word transfer, entered just after a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hrdyo !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		if (!wr) exp_q.push_back(e);
		do @(posedge clk); while (hrdyo !== 1'b1);
	endtask
	task automatic close_out;
		// a read note never compared counts as a miss
		if (exp_q.size() != 0) fails++;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	//----------------------------------------
	// scenarios
	//----------------------------------------
	initial begin
		void'($urandom(66));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		bus(1'b1, 8'hf7, 32'h0, 32'h0);
		bus(1'b1, 8'hf8, 32'h0, 32'h0);
		bus(0, 8'hf2, 0, 32'h9);
		bus(0, 8'hf8, 0, 32'h0);
		bus(0, 8'h40, 0, 32'h0);
		// global enable on, so only the cleared mask can hold it back
		gie <= 1'b1;
		repeat (60) @(posedge clk);
		chk("masked_irq", 0, irq);
		bus(0, 8'hf0, 0, 32'h4);
		// each tau ratio, random legal count
		for (int s = 0; s < 4; s++) begin
			dv = 2 * (s == 0 ? 12 : s == 1 ? 16 : s == 2 ? 20 : 32);
			bus(1'b1, 8'hf2, 32'h4, 0);
			for (c = 0; c < 200 && run !== 1'b0; c++) @(posedge clk);
			chk("stop_time", 1, c <= dv + 4);
			bus(1'b1, 8'hf7, s, 0);
			bus(1'b1, 8'hf2, 32'hc, 0);
			n = $urandom % 15;
			bus(1'b1, 8'hf8, n, 0);
			for (c = 0; c < 3000 && irq !== 1'b1; c++) @(posedge clk);
			// restarted tau: first rise a full tau on, then n more
			chk("irq_time", 1, c >= (n + 1) * dv - 4 &&
				c <= (n + 1) * dv + 4);
			bus(0, 8'hf0, 0, 32'h4);
			bus(0, 8'hf0, 0, 32'h0);
		end
		// global enable holds the request back
		gie <= 1'b0;
		bus(1'b1, 8'hf8, 32'h1, 0);
		repeat (200) @(posedge clk);
		chk("gie_off", 0, irq);
		gie <= 1'b1;
		@(posedge clk);
		#1 chk("gie_on", 1, irq);
		@(posedge clk);
		bus(0, 8'hf0, 0, 32'h4);
		ce <= 1'b0;
		repeat (5) @(posedge clk);
		ce <= 1'b1;
		bus(0, 8'hf2, 0, 32'hd);
		// let the monitor take the last read before the verdict
		@(posedge clk);
		close_out();
	end
	// watchdog: the whole sequence needs well under 40000 cycles
	initial begin
		#(40 * 40000);
		fails++;
		close_out();
	end
endmodule
`default_nettype wire
